// *** hdl/dpsc_params.svh ***
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH

// Clock period in picoseconds (100 MHz)
`define DPSC_CLK_PS 10000
// Pin and word widths
`define DPSC_ADDR_W 9
`define DPSC_DATA_W 4
`define DPSC_LOC_W 18
// Nanoseconds to whole clock cycles, rounded up
`define DPSC_NS2CYC(t) (((t) * 1000 + `DPSC_CLK_PS - 1) / `DPSC_CLK_PS)
// Row strobe precharge (high) time, ns, and its cycle count
`define DPSC_T_RP_NS 90
`define DPSC_RP_CYC `DPSC_NS2CYC(`DPSC_T_RP_NS)
// Address setup ahead of a strobe fall, ns
`define DPSC_T_ASU_NS 10
`define DPSC_ASU_CYC `DPSC_NS2CYC(`DPSC_T_ASU_NS)
// Row address hold after row strobe fall, ns
`define DPSC_T_RAH_NS 15
`define DPSC_RAH_CYC `DPSC_NS2CYC(`DPSC_T_RAH_NS)
// Row strobe access time, ns (read data wait from column strobe fall)
`define DPSC_T_RAC_NS 150
`define DPSC_RAC_CYC `DPSC_NS2CYC(`DPSC_T_RAC_NS)
// Column strobe low pulse, ns
`define DPSC_T_CAS_NS 40
`define DPSC_CAS_CYC `DPSC_NS2CYC(`DPSC_T_CAS_NS)
// Longest row strobe low time, ns (rounded down)
`define DPSC_T_RASMAX_NS 10000
`define DPSC_RASMAX_CYC ((`DPSC_T_RASMAX_NS * 1000) / `DPSC_CLK_PS)
// Refresh period in ms over 512 rows, per-row interval in cycles
`define DPSC_T_REF_MS 8
`define DPSC_REF_ROWS 512
`define DPSC_REF_CYC ((`DPSC_T_REF_MS * 100000) / `DPSC_REF_ROWS)
// Power-up pause in us, and initialization cycles
`define DPSC_T_PWR_US 200
`define DPSC_PWR_CYC (`DPSC_T_PWR_US * 100)
`define DPSC_INIT_CYCLES 8
// Wait counter width
`define DPSC_CNT_W 16

`endif

// *** hdl/dpsc_pkg.sv ***
package dpsc_pkg;
   typedef enum logic [3:0] {
      ST_PWRUP = 4'h0,
      ST_PRE = 4'h1,
      ST_ROW = 4'h2,
      ST_RAH = 4'h3,
      ST_COL = 4'h4,
      ST_CLOW = 4'h5,
      ST_CHIGH = 4'h6,
      ST_CBR_C = 4'h7,
      ST_CBR_R = 4'h8,
      ST_IDLE = 4'h9
   } dpsc_state_e;
endpackage

// *** hdl/dpsc_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for the read data lines
module dpsc_sync (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] d_i,
   output logic [3:0] q_o
);
   logic [3:0] meta_q;
   logic [3:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end
   assign q_o = sync_q;
endmodule

// *** hdl/dpsc_host.sv ***
`timescale 1ns/1ps
`include "dpsc_params.svh"
// What this block does
// - Address stable before each strobe fall
// - Static writes toggle write select
// - Output enable high before driving data
// - All 512 rows refreshed in 8 ms
// - Pause then eight init cycles
module dpsc_host (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic req_we_i,
   input wire logic [17:0] req_addr_i,
   input wire logic [3:0] req_wdata_i,
   input wire logic [3:0] dq_i,
   output logic req_ready_o,
   output logic rd_valid_o,
   output logic [3:0] rd_data_o,
   output logic init_done_o,
   output logic [8:0] mux_address_pins_o,
   output logic row_strobe_n_o,
   output logic col_strobe_n_o,
   output logic write_sel_n_o,
   output logic out_en_n_o,
   output logic [3:0] dq_o,
   output logic dq_oe_o
);
   typedef struct packed {
      dpsc_pkg::dpsc_state_e st;
      logic [15:0] cnt;
      logic [15:0] ras_cnt;
      logic [15:0] ref_cnt;
      logic ref_pend;
      logic [3:0] init_n;
      logic we;
      logic [8:0] row;
      logic [8:0] col;
      logic [3:0] wdata;
      logic [8:0] addr;
      logic ras_n;
      logic cas_n;
      logic w_n;
      logic g_n;
      logic [3:0] dq;
      logic dq_oe;
      logic ready;
      logic rvalid;
      logic [3:0] rdata;
      logic done;
   } dpsc_host_s;

   dpsc_host_s s_q;
   dpsc_host_s s_d;
   logic [3:0] dq_sync;

   dpsc_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .d_i(dq_i),
      .q_o(dq_sync)
   );

   // True when a pending request continues the open row
   function automatic logic same_row(input logic [17:0] a,
                                     input logic [8:0] r);
      same_row = (a[17:9] == r);
   endfunction

   // Next-state logic of the whole controller
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.ready = 1'b0;
      s_d.cnt = (s_q.cnt != 16'h0000) ? s_q.cnt - 16'h0001 : 16'h0000;
      s_d.ras_cnt = s_q.ras_n ? 16'h0000 : s_q.ras_cnt + 16'h0001;
      // Refresh interval timer, one row every 8 ms / 512
      if (s_q.ref_cnt >= 16'(`DPSC_REF_CYC - 1)) begin
         s_d.ref_cnt = 16'h0000;
         s_d.ref_pend = 1'b1;
      end else begin
         s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
      end
      case (s_q.st)
         dpsc_pkg::ST_PWRUP: begin
            // Pause after power up, strobes idle high
            if (s_q.cnt == 16'h0000) begin
               s_d.st = dpsc_pkg::ST_PRE;
               s_d.cnt = 16'(`DPSC_RP_CYC);
            end
         end
         dpsc_pkg::ST_PRE: begin
            // Row strobe precharge before any new row cycle
            s_d.ras_n = 1'b1;
            s_d.cas_n = 1'b1;
            s_d.w_n = 1'b1;
            s_d.g_n = 1'b1;
            s_d.dq_oe = 1'b0;
            if (s_q.cnt == 16'h0000) begin
               s_d.st = dpsc_pkg::ST_IDLE;
            end
         end
         dpsc_pkg::ST_IDLE: begin
            if (s_q.ref_pend || !s_q.done) begin
               // Column-before-row refresh, also used for init cycles
               s_d.cas_n = 1'b0;
               s_d.ref_pend = (s_d.ref_cnt == 16'h0000);
               s_d.st = dpsc_pkg::ST_CBR_C;
               s_d.cnt = 16'(`DPSC_ASU_CYC);
            end else if (req_i) begin
               s_d.ready = 1'b1;
               s_d.we = req_we_i;
               s_d.row = req_addr_i[17:9];
               s_d.col = req_addr_i[8:0];
               s_d.wdata = req_wdata_i;
               s_d.addr = req_addr_i[17:9];
               s_d.st = dpsc_pkg::ST_ROW;
               s_d.cnt = 16'(`DPSC_ASU_CYC);
            end
         end
         dpsc_pkg::ST_CBR_C: begin
            if (s_q.cnt == 16'h0000) begin
               s_d.ras_n = 1'b0;
               s_d.st = dpsc_pkg::ST_CBR_R;
               s_d.cnt = 16'(`DPSC_RAC_CYC);
            end
         end
         dpsc_pkg::ST_CBR_R: begin
            if (s_q.cnt == 16'h0000) begin
               if (!s_q.done) begin
                  s_d.init_n = s_q.init_n + 4'h1;
                  s_d.done = (s_q.init_n == 4'(`DPSC_INIT_CYCLES - 1));
               end
               s_d.st = dpsc_pkg::ST_PRE;
               s_d.cnt = 16'(`DPSC_RP_CYC);
            end
         end
         dpsc_pkg::ST_ROW: begin
            // Row address set up before the row strobe falls
            if (s_q.cnt == 16'h0000) begin
               s_d.ras_n = 1'b0;
               s_d.st = dpsc_pkg::ST_RAH;
               s_d.cnt = 16'(`DPSC_RAH_CYC);
            end
         end
         dpsc_pkg::ST_RAH: begin
            // Hold row, then present column while column strobe high
            if (s_q.cnt == 16'h0000) begin
               s_d.addr = s_q.col;
               s_d.w_n = !s_q.we;
               s_d.dq = s_q.wdata;
               s_d.dq_oe = s_q.we;
               s_d.st = dpsc_pkg::ST_COL;
               s_d.cnt = 16'(`DPSC_ASU_CYC);
            end
         end
         dpsc_pkg::ST_COL: begin
            // Early write: select low before column strobe falls
            if (s_q.cnt == 16'h0000) begin
               s_d.cas_n = 1'b0;
               s_d.g_n = s_q.we;
               s_d.st = dpsc_pkg::ST_CLOW;
               s_d.cnt = s_q.we ? 16'(`DPSC_CAS_CYC) :
                         16'(`DPSC_RAC_CYC);
            end
         end
         dpsc_pkg::ST_CLOW: begin
            // Read sampled after the full access time
            if (s_q.cnt == 16'h0000) begin
               s_d.rvalid = !s_q.we;
               s_d.rdata = dq_sync;
               s_d.cas_n = 1'b1;
               s_d.g_n = 1'b1;
               s_d.w_n = 1'b1;
               s_d.dq_oe = 1'b0;
               s_d.st = dpsc_pkg::ST_CHIGH;
               s_d.cnt = 16'(`DPSC_ASU_CYC);
            end
         end
         dpsc_pkg::ST_CHIGH: begin
            // Stay in page while same row and row-low limit allows
            if (s_q.cnt == 16'h0000) begin
               if (req_i && !s_q.ref_pend && same_row(req_addr_i, s_q.row)
                   && s_q.ras_cnt < 16'(`DPSC_RASMAX_CYC / 2)) begin
                  s_d.ready = 1'b1;
                  s_d.we = req_we_i;
                  s_d.col = req_addr_i[8:0];
                  s_d.wdata = req_wdata_i;
                  s_d.addr = req_addr_i[8:0];
                  s_d.w_n = !req_we_i;
                  s_d.dq = req_wdata_i;
                  s_d.dq_oe = req_we_i;
                  s_d.st = dpsc_pkg::ST_COL;
                  s_d.cnt = 16'(`DPSC_ASU_CYC);
               end else begin
                  s_d.ras_n = 1'b1;
                  s_d.st = dpsc_pkg::ST_PRE;
                  s_d.cnt = 16'(`DPSC_RP_CYC);
               end
            end
         end
         default: s_d.st = dpsc_pkg::ST_PRE;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
         s_q.st <= dpsc_pkg::ST_PWRUP;
         s_q.cnt <= 16'(`DPSC_PWR_CYC);
         s_q.ras_n <= 1'b1;
         s_q.cas_n <= 1'b1;
         s_q.w_n <= 1'b1;
         s_q.g_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready_o = s_q.ready;
   assign rd_valid_o = s_q.rvalid;
   assign rd_data_o = s_q.rdata;
   assign init_done_o = s_q.done;
   assign mux_address_pins_o = s_q.addr;
   assign row_strobe_n_o = s_q.ras_n;
   assign col_strobe_n_o = s_q.cas_n;
   assign write_sel_n_o = s_q.w_n;
   assign out_en_n_o = s_q.g_n;
   assign dq_o = s_q.dq;
   assign dq_oe_o = s_q.dq_oe;

   // Never drive data while the memory output is enabled
   no_contend_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      dq_oe_o |-> out_en_n_o)
      else $error("data driven with output on");
   // Row strobe never stays low beyond its limit
   ras_limit_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      s_q.ras_cnt < 16'(`DPSC_RASMAX_CYC))
      else $error("row low too long");
   // Column strobe falls only with the column address steady
   addr_stable_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(col_strobe_n_o) && !row_strobe_n_o |->
      $stable(mux_address_pins_o))
      else $error("address moved at column fall");
   // Write select is low before column strobe falls in writes
   early_wr_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(col_strobe_n_o) && dq_oe_o |-> !$past(write_sel_n_o))
      else $error("write select late");
   // Row address held on the pins after the row strobe falls
   row_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(row_strobe_n_o) |=> $stable(mux_address_pins_o))
      else $error("row address not held");
   // Refresh cycles drop the column strobe ahead of the row strobe
   cbr_order_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(row_strobe_n_o) && !col_strobe_n_o |-> !$past(col_strobe_n_o))
      else $error("column strobe not ahead of row");
   // A read result only follows the end of a column strobe
   rd_after_cas_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      rd_valid_o |-> $rose(col_strobe_n_o))
      else $error("read result without column end");
endmodule

// *** test/dpsc_mem_model.sv ***
`timescale 1ns/1ps
// Behavioural strobe-driven memory, one 4-bit word per 18-bit location
module dpsc_mem_model (
   input wire logic [8:0] addr_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [3:0] dq_i,
   input wire logic slow_i,
   output logic [3:0] dq_o,
   output logic drv_o,
   output int cbr_o
);
   logic [3:0] mem [logic [17:0]];
   logic [8:0] row_q;
   logic [17:0] loc_q;
   logic [3:0] rd_q;
   initial begin
      drv_o = 1'b0;
      cbr_o = 0;
      rd_q = 4'h0;
   end
   // Row strobe fall opens a row, or refreshes an internal row
   always @(negedge ras_n_i) begin
      if (!cas_n_i) cbr_o = cbr_o + 1;
      else row_q = addr_i;
   end
   // Column strobe fall latches the column, then writes or reads
   always @(negedge cas_n_i) begin
      if (!ras_n_i) begin
         loc_q = {row_q, addr_i};
         if (!we_n_i) mem[loc_q] = dq_i;
         else begin
            #(slow_i ? 100 : 40);
            rd_q = mem.exists(loc_q) ? mem[loc_q] : 4'h5;
            if (!cas_n_i && !oe_n_i) drv_o = 1'b1;
         end
      end
   end
   // Delayed write: data taken at the write select fall
   always @(negedge we_n_i) begin
      if (!ras_n_i && !cas_n_i) mem[loc_q] = dq_i;
   end
   // Either enable going high floats the outputs
   always @(posedge cas_n_i or posedge oe_n_i) drv_o = 1'b0;
   // Floating lines show the inverse of the last word
   assign dq_o = drv_o ? rd_q : ~rd_q;
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "dpsc_params.svh"
module tb_top;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic req_i = 1'b0;
   logic req_we_i = 1'b0;
   logic slow = 1'b0;
   logic [17:0] req_addr_i = 18'h00000;
   logic [3:0] req_wdata_i = 4'h0;
   logic [15:0] lf = 16'h0012;
   logic [3:0] mdq, bus, rd_data_o, dq_o;
   logic [8:0] mux_o;
   logic req_ready_o, rd_valid_o, init_done_o, ras_n, cas_n, we_n, oe_n;
   logic dq_oe_o, mdrv;
   logic [3:0] shadow [logic [17:0]];
   logic [3:0] exp_q [$];
   logic [17:0] adr [8];
   int err_total = 0, checks = 0, cbr, ras_lo = 0, ref_gap = 0, n;
   int cbr_seen = 0;
   realtime t_adr = 0;
   // Data lines resolved from both drivers
   assign bus = dq_oe_o ? dq_o : mdq;
   dpsc_host dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req_i),
      .req_we_i(req_we_i), .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i), .dq_i(bus), .req_ready_o(req_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .init_done_o(init_done_o), .mux_address_pins_o(mux_o),
      .row_strobe_n_o(ras_n), .col_strobe_n_o(cas_n),
      .write_sel_n_o(we_n), .out_en_n_o(oe_n), .dq_o(dq_o),
      .dq_oe_o(dq_oe_o));
   dpsc_mem_model mem (.addr_i(mux_o), .ras_n_i(ras_n), .cas_n_i(cas_n),
      .we_n_i(we_n), .oe_n_i(oe_n), .dq_i(bus), .slow_i(slow),
      .dq_o(mdq), .drv_o(mdrv), .cbr_o(cbr));
   // Clock
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Corner location of the page test
   function automatic logic [17:0] pg(input int r, input int c);
      return {9'(r * 511), 9'(c < 2 ? c : 508 + c)};
   endfunction
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One request, held until taken; expected read word queued
   task automatic xfer(input logic we, input logic [17:0] a,
                       input logic [3:0] wd);
      int k;
      k = 0;
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      req_we_i <= we;
      req_addr_i <= a;
      req_wdata_i <= wd;
      if (we) shadow[a] = wd;
      else exp_q.push_back(shadow.exists(a) ? shadow[a] : 4'h5);
      do begin
         @(negedge ref_clk_i);
         k++;
      end while (req_ready_o !== 1'b1 && k < 4000);
      if (k >= 4000) chk(4'h0, 4'h1);
      @(posedge ref_clk_i);
      req_i <= 1'b0;
   endtask
   // Returned words against the oldest note
   always @(negedge ref_clk_i) begin
      if (rd_valid_o === 1'b1) begin
         if (exp_q.size() == 0) chk(4'h0, 4'h1);
         else chk(rd_data_o, exp_q.pop_front());
      end
      if (dq_oe_o === 1'b1 && mdrv) chk(4'h1, 4'h0);
      if (ras_lo > `DPSC_RASMAX_CYC) chk(4'h2, 4'h0);
      if (ref_gap > 2 * `DPSC_REF_CYC) chk(4'h3, 4'h0);
   end
   // Row-low time and refresh spacing counters
   always @(posedge ref_clk_i) begin
      ras_lo <= (ras_n === 1'b0) ? ras_lo + 1 : 0;
      ref_gap <= (init_done_o !== 1'b1 || cbr != cbr_seen) ? 0 :
                 ref_gap + 1;
      cbr_seen <= cbr;
   end
   // Address must settle before each capturing strobe fall
   always @(mux_o) t_adr = $realtime;
   always @(negedge ras_n) begin
      if (cas_n === 1'b1 && $realtime - t_adr < `DPSC_T_ASU_NS)
         chk(4'h4, 4'h0);
   end
   always @(negedge cas_n) begin
      if (ras_n === 1'b0 && $realtime - t_adr < `DPSC_T_ASU_NS)
         chk(4'h6, 4'h0);
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      n = 0;
      while (init_done_o !== 1'b1 && n < 30000) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(4'(init_done_o), 4'h1);
      chk(4'(cbr >= 8), 4'h1);
      $display("test init done");
      // Random locations written, then read back
      for (int i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         adr[i] = {lf, lf[15:14]};
         xfer(1'b1, adr[i], lf[3:0]);
      end
      for (int i = 0; i < 8; i++) xfer(1'b0, adr[i], 4'h0);
      $display("test random done");
      // Corner rows and columns, same-row requests back to back
      for (int r = 0; r < 2; r++) begin
         for (int c = 0; c < 4; c++)
            xfer(1'b1, pg(r, c), 4'(c + 4 * r));
         for (int c = 0; c < 4; c++)
            xfer(1'b0, pg(r, c), 4'h0);
      end
      $display("test page done");
      // Slow memory answers
      slow = 1'b1;
      for (int i = 0; i < 3; i++) xfer(1'b0, adr[i], 4'h0);
      // Keep the slow answers until every slow read has returned
      while (exp_q.size() != 0) @(negedge ref_clk_i);
      slow = 1'b0;
      $display("test slow done");
      // Idle across refresh intervals, data retained
      n = cbr;
      repeat (4000) @(posedge ref_clk_i);
      chk(4'(cbr >= n + 2), 4'h1);
      xfer(1'b0, {9'h1FF, 9'h1FF}, 4'h0);
      xfer(1'b0, adr[7], 4'h0);
      n = 0;
      while (exp_q.size() != 0 && n < 2000) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(4'(exp_q.size()), 4'h0);
      $display("test refresh done");
      end_of_test();
   end
endmodule
